// ==== scf_regs.svh ====
// constants for the suspend command filter: offsets, fields, timing, codes
// assumes a 40 MHz core clock and a plain register port
`ifndef SCF_REGS_SVH
`define SCF_REGS_SVH
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define SCF_REG_IRQ_STATUS 8'h00
`define SCF_REG_IRQ_MASK 8'h04
`define SCF_REG_STATE 8'h08
`define SCF_REG_LAST_CMD 8'h0c
`define SCF_IRQ_W 3
`define SCF_IRQ_RST 3'h0
`define SCF_EV_SUSPENDED 0
`define SCF_EV_RESUMED 1
`define SCF_EV_REJECTED 2
`define SCF_ST_PROG_BIT 15
`define SCF_ST_ERASE_BIT 10
`define SCF_ST_PENDING_BIT 2
`define SCF_ST_WEL_BIT 1
`define SCF_ST_WIP_BIT 0
// ----------------------------------------
// timing
// ----------------------------------------
`define SCF_CLK_MHZ 40
`define SCF_PSL_NS 20000
`define SCF_ESL_NS 20000
`define SCF_PSL_CYC ((`SCF_PSL_NS*`SCF_CLK_MHZ+999)/1000)
`define SCF_ESL_CYC ((`SCF_ESL_NS*`SCF_CLK_MHZ+999)/1000)
`define SCF_LAT_W 12
// ----------------------------------------
// instruction codes
// ----------------------------------------
`define SCF_OP_WR_EN 8'h06
`define SCF_OP_WR_DIS 8'h04
`define SCF_OP_RD_XADDR 8'hc8
`define SCF_OP_WR_XADDR 8'hc5
`define SCF_OP_EN4B 8'hb7
`define SCF_OP_EX4B 8'he9
`define SCF_OP_QCM_ON 8'h38
`define SCF_OP_QCM_OFF 8'hff
`define SCF_OP_READ 8'h03
`define SCF_OP_READ4 8'h13
`define SCF_OP_FREAD 8'h0b
`define SCF_OP_FREAD_DT 8'h0d
`define SCF_OP_FREAD4 8'h0c
`define SCF_OP_DOUT 8'h3b
`define SCF_OP_DOUT4 8'h3c
`define SCF_OP_QOUT 8'h6b
`define SCF_OP_QOUT4 8'h6c
`define SCF_OP_DIO 8'hbb
`define SCF_OP_DIO_DT 8'hbd
`define SCF_OP_DIO4 8'hbc
`define SCF_OP_QIO 8'heb
`define SCF_OP_QIO_DT 8'hed
`define SCF_OP_QIO4 8'hec
`define SCF_OP_QIO4_DT 8'hee
`define SCF_OP_QWORD 8'he7
`define SCF_OP_WRAP 8'h77
`define SCF_OP_RD_PARAM 8'hc0
`define SCF_OP_ID 8'h90
`define SCF_OP_ID_D 8'h92
`define SCF_OP_ID_Q 8'h94
`define SCF_OP_JID 8'h9f
`define SCF_OP_UID 8'h4b
`define SCF_OP_WAKE 8'hab
`define SCF_OP_SECR 8'h48
`define SCF_OP_PTAB 8'h5a
`define SCF_OP_RESUME 8'h7a
`define SCF_OP_LOCK 8'h2d
`define SCF_OP_LKBIT 8'ha7
`define SCF_OP_SOLID 8'he2
`define SCF_OP_DYN 8'h3d
`define SCF_OP_UNPROT 8'haa
`define SCF_OP_PASS 8'h27
`define SCF_OP_PP 8'h02
`define SCF_OP_PP4 8'h12
`define SCF_OP_QPP 8'h32
`define SCF_OP_QPP4 8'h34
`define SCF_OP_SE 8'h20
`define SCF_OP_SE4 8'h21
`define SCF_OP_BE32 8'h52
`define SCF_OP_BE32_4 8'h5c
`define SCF_OP_BE64 8'hd8
`define SCF_OP_BE64_4 8'hdc
`define SCF_OP_RDSR1 8'h05
`define SCF_OP_RDSR2 8'h35
`define SCF_OP_RDSR3 8'h15
`define SCF_OP_RST_EN 8'h66
`define SCF_OP_RST 8'h99
`define SCF_OP_SUSPEND 8'h75
`endif

// ==== scf_pkg.sv ====
// types shared by the suspend command filter
// assumes nothing beyond a SystemVerilog compiler
package scf_pkg;
   // kind of operation the array engine is running
   typedef enum logic [1:0] {
      op_none,
      op_program,
      op_erase,
      op_status
   } scf_op_t;
   // suspend sequencing state
   typedef enum logic [1:0] {
      st_run,
      st_pending,
      st_suspended
   } scf_state_t;
endpackage

// ==== scf_suspend_filter.sv ====
// suspend state tracker and instruction filter of a serial nor flash
// assumes the serial pins are asynchronous to i_clock and that the array
// engine drives i_wip and i_op_kind from i_clock
//
// Overview of operation
// - program-suspended flag, status bit 15, set once a program is suspended.
// - erase-suspended flag, status bit 10, set once an erase is suspended.
// - resuming clears the matching suspended flag.
// - while suspended, accept write enable/disable, address modes, quad mode.
// - while suspended, accept single-line reads, normal, fast and double rate.
// - while suspended, accept dual and quad fast reads and all variants.
// - while suspended, accept id reads, table reads, wrap, parameters, wake.
// - page programs accepted only while an erase is suspended.
// - sector and block erases accepted only while a program is suspended.
// - while suspended, accept the protection-related register reads.
// - status reads and reset accepted right after suspend, no latency.
// - after latency, clear write enable latch, set flag, then accept.
// - suspend interrupts program or erase; status writes cannot suspend.
// - resume acts only with suspend flag set and no write in progress.
`timescale 1ns/1ps
`include "scf_regs.svh"
module scf_suspend_filter (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // serial link pins
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic [3:0] i_io,
   // array engine
   input wire logic i_wip,
   input wire scf_pkg::scf_op_t i_op_kind,
   output logic o_suspend_start,
   output logic o_resume_start,
   // decoded instruction stream
   output logic o_cmd_valid,
   output logic o_cmd_accept,
   output logic [7:0] o_cmd_code,
   // status flags
   output logic o_program_suspended,
   output logic o_erase_suspended,
   output logic o_write_enable_latch,
   output logic o_quad_command_mode,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_write,
   input wire logic i_read,
   output logic [31:0] o_rdata,
   output logic o_irq
);
   import scf_pkg::*;

   // ----------------------------------------
   // decode functions
   // ----------------------------------------
   // commands that need no latency after a suspend
   function automatic logic scf_no_latency(input logic [7:0] op);
      case (op)
         `SCF_OP_RDSR1, `SCF_OP_RDSR2, `SCF_OP_RDSR3,
         `SCF_OP_RST_EN, `SCF_OP_RST: scf_no_latency = 1'b1;
         default: scf_no_latency = 1'b0;
      endcase
   endfunction

   // allowed set once the suspend has settled
   function automatic logic scf_allowed(input logic [7:0] op,
                                        input logic prog,
                                        input logic ers);
      case (op)
         `SCF_OP_WR_EN, `SCF_OP_WR_DIS, `SCF_OP_RD_XADDR, `SCF_OP_WR_XADDR,
         `SCF_OP_EN4B, `SCF_OP_EX4B, `SCF_OP_QCM_ON,
         `SCF_OP_QCM_OFF: scf_allowed = 1'b1;
         `SCF_OP_READ, `SCF_OP_READ4, `SCF_OP_FREAD, `SCF_OP_FREAD_DT,
         `SCF_OP_FREAD4: scf_allowed = 1'b1;
         `SCF_OP_DOUT, `SCF_OP_DOUT4, `SCF_OP_QOUT, `SCF_OP_QOUT4,
         `SCF_OP_DIO, `SCF_OP_DIO_DT, `SCF_OP_DIO4, `SCF_OP_QIO,
         `SCF_OP_QIO_DT, `SCF_OP_QIO4, `SCF_OP_QIO4_DT,
         `SCF_OP_QWORD: scf_allowed = 1'b1;
         `SCF_OP_WRAP, `SCF_OP_RD_PARAM, `SCF_OP_ID, `SCF_OP_ID_D,
         `SCF_OP_ID_Q, `SCF_OP_JID, `SCF_OP_UID, `SCF_OP_WAKE,
         `SCF_OP_SECR, `SCF_OP_PTAB: scf_allowed = 1'b1;
         `SCF_OP_LOCK, `SCF_OP_LKBIT, `SCF_OP_SOLID, `SCF_OP_DYN,
         `SCF_OP_UNPROT, `SCF_OP_PASS: scf_allowed = 1'b1;
         `SCF_OP_PP, `SCF_OP_PP4, `SCF_OP_QPP,
         `SCF_OP_QPP4: scf_allowed = ers & ~prog;
         `SCF_OP_SE, `SCF_OP_SE4, `SCF_OP_BE32, `SCF_OP_BE32_4,
         `SCF_OP_BE64, `SCF_OP_BE64_4:
            scf_allowed = prog & ~ers;
         `SCF_OP_RESUME: scf_allowed = 1'b1;
         default: scf_allowed = scf_no_latency(op);
      endcase
   endfunction

   // ----------------------------------------
   // pin synchronisers and edge finding
   // ----------------------------------------
   logic sck_meta, sck_sync, sck_last;
   logic cs_meta, cs_sync, cs_last;
   logic [3:0] io_meta, io_sync;
   logic sck_rise, cs_rise;

   // two stages on every pin, the first read by nothing else
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sck_meta <= 1'b0;
         sck_sync <= 1'b0;
         sck_last <= 1'b0;
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         cs_last <= 1'b1;
         io_meta <= 4'h0;
         io_sync <= 4'h0;
      end else begin
         sck_meta <= i_sck;
         sck_sync <= sck_meta;
         sck_last <= sck_sync;
         cs_meta <= i_cs_n;
         cs_sync <= cs_meta;
         cs_last <= cs_sync;
         io_meta <= i_io;
         io_sync <= io_meta;
      end
   end

   assign sck_rise = sck_sync & ~sck_last;
   assign cs_rise = cs_sync & ~cs_last;

   // ----------------------------------------
   // instruction capture
   // ----------------------------------------
   logic [7:0] shreg, next_shreg;
   logic [3:0] bit_cnt, next_cnt;
   logic captured;
   logic quad_command_mode;

   // quad mode moves four bits per edge, single mode one on io0
   always_comb begin
      if (quad_command_mode) begin
         next_shreg = {shreg[3:0], io_sync};
         next_cnt = bit_cnt + 4'h4;
      end else begin
         next_shreg = {shreg[6:0], io_sync[0]};
         next_cnt = bit_cnt + 4'h1;
      end
   end

   // only the first byte of a frame is an instruction
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         shreg <= 8'h00;
         bit_cnt <= 4'h0;
         captured <= 1'b0;
      end else if (cs_sync) begin
         bit_cnt <= 4'h0;
         captured <= 1'b0;
      end else if (sck_rise && !captured) begin
         shreg <= next_shreg;
         bit_cnt <= next_cnt;
         captured <= (next_cnt == 4'h8);
      end
   end

   logic op_strobe;
   logic [7:0] op_code;

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         op_strobe <= 1'b0;
         op_code <= 8'h00;
      end else begin
         op_strobe <= !cs_sync && sck_rise && !captured &&
                      (next_cnt == 4'h8);
         if (!cs_sync && sck_rise && !captured && next_cnt == 4'h8)
            op_code <= next_shreg;
      end
   end

   // ----------------------------------------
   // acceptance decision
   // ----------------------------------------
   scf_state_t state;
   logic program_suspended_flag, erase_suspended_flag, suspend_flag;
   logic accept;

   assign suspend_flag = program_suspended_flag | erase_suspended_flag;

   always_comb begin
      accept = 1'b1;
      case (state)
         st_run: begin
            if (op_code == `SCF_OP_SUSPEND)
               accept = i_wip && (i_op_kind == op_program ||
                                  i_op_kind == op_erase);
            else if (op_code == `SCF_OP_RESUME)
               accept = 1'b0;
         end
         // until the latency ends only status and reset get through
         st_pending: accept = scf_no_latency(op_code);
         st_suspended: begin
            if (op_code == `SCF_OP_RESUME)
               accept = suspend_flag && !i_wip;
            else
               accept = scf_allowed(op_code, program_suspended_flag,
                                    erase_suspended_flag);
         end
         default: accept = 1'b0;
      endcase
   end

   // accepted instruction waits for the end of its frame
   // held drops at frame end so an empty frame cannot replay it
   logic held;
   logic last_accept;
   logic [7:0] held_code;

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         held <= 1'b0;
         last_accept <= 1'b0;
         held_code <= 8'h00;
      end else if (op_strobe) begin
         held <= accept;
         last_accept <= accept;
         held_code <= op_code;
      end else if (cs_rise) begin
         held <= 1'b0;
      end
   end

   // instruction stream seen by the command engines
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_cmd_valid <= 1'b0;
         o_cmd_accept <= 1'b0;
         o_cmd_code <= 8'h00;
      end else begin
         o_cmd_valid <= op_strobe;
         o_cmd_accept <= op_strobe & accept;
         if (op_strobe)
            o_cmd_code <= op_code;
      end
   end

   // ----------------------------------------
   // suspend sequencing
   // ----------------------------------------
   logic frame_done;
   logic [`SCF_LAT_W-1:0] lat_cnt;
   logic pend_erase;
   logic reset_armed;
   logic write_enable_latch;
   logic ev_suspended, ev_resumed;

   assign frame_done = cs_rise & held;

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= st_run;
         lat_cnt <= '0;
         pend_erase <= 1'b0;
         program_suspended_flag <= 1'b0;
         erase_suspended_flag <= 1'b0;
         reset_armed <= 1'b0;
         o_suspend_start <= 1'b0;
         o_resume_start <= 1'b0;
         ev_suspended <= 1'b0;
         ev_resumed <= 1'b0;
      end else begin
         o_suspend_start <= 1'b0;
         o_resume_start <= 1'b0;
         ev_suspended <= 1'b0;
         ev_resumed <= 1'b0;
         if (frame_done)
            reset_armed <= (held_code == `SCF_OP_RST_EN);
         // software reset abandons any suspended operation
         if (frame_done && held_code == `SCF_OP_RST && reset_armed) begin
            state <= st_run;
            program_suspended_flag <= 1'b0;
            erase_suspended_flag <= 1'b0;
         end else begin
            case (state)
               st_run: begin
                  if (frame_done && held_code == `SCF_OP_SUSPEND) begin
                     state <= st_pending;
                     o_suspend_start <= 1'b1;
                     pend_erase <= (i_op_kind == op_erase);
                     if (i_op_kind == op_erase)
                        lat_cnt <= `SCF_LAT_W'(`SCF_ESL_CYC - 1);
                     else
                        lat_cnt <= `SCF_LAT_W'(`SCF_PSL_CYC - 1);
                  end
               end
               st_pending: begin
                  if (lat_cnt == '0) begin
                     state <= st_suspended;
                     ev_suspended <= 1'b1;
                     if (pend_erase)
                        erase_suspended_flag <= 1'b1;
                     else
                        program_suspended_flag <= 1'b1;
                  end else begin
                     lat_cnt <= lat_cnt - `SCF_LAT_W'(1);
                  end
               end
               st_suspended: begin
                  if (frame_done && held_code == `SCF_OP_RESUME) begin
                     state <= st_run;
                     program_suspended_flag <= 1'b0;
                     erase_suspended_flag <= 1'b0;
                     o_resume_start <= 1'b1;
                     ev_resumed <= 1'b1;
                  end
               end
               default: state <= st_run;
            endcase
         end
      end
   end

   // write enable latch and quad mode follow accepted frames
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         write_enable_latch <= 1'b0;
         quad_command_mode <= 1'b0;
      end else begin
         if (state == st_pending && lat_cnt == '0)
            write_enable_latch <= 1'b0;
         else if (frame_done && held_code == `SCF_OP_WR_EN)
            write_enable_latch <= 1'b1;
         else if (frame_done && held_code == `SCF_OP_WR_DIS)
            write_enable_latch <= 1'b0;
         if (frame_done && held_code == `SCF_OP_QCM_ON)
            quad_command_mode <= 1'b1;
         else if (frame_done && held_code == `SCF_OP_QCM_OFF)
            quad_command_mode <= 1'b0;
      end
   end

   assign o_program_suspended = program_suspended_flag;
   assign o_erase_suspended = erase_suspended_flag;
   assign o_write_enable_latch = write_enable_latch;
   assign o_quad_command_mode = quad_command_mode;

   // ----------------------------------------
   // interrupt status, mask and register port
   // ----------------------------------------
   logic [`SCF_IRQ_W-1:0] irq_status, irq_mask, events, clr;

   always_comb begin
      events = '0;
      events[`SCF_EV_SUSPENDED] = ev_suspended;
      events[`SCF_EV_RESUMED] = ev_resumed;
      events[`SCF_EV_REJECTED] = op_strobe & ~accept;
      clr = '0;
      if (i_write && i_addr == `SCF_REG_IRQ_STATUS)
         clr = i_wdata[`SCF_IRQ_W-1:0];
   end

   // a new event wins over a clear in the same cycle
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_status <= `SCF_IRQ_RST;
         irq_mask <= `SCF_IRQ_RST;
         o_irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~clr) | events;
         if (i_write && i_addr == `SCF_REG_IRQ_MASK)
            irq_mask <= i_wdata[`SCF_IRQ_W-1:0];
         o_irq <= |(irq_status & irq_mask);
      end
   end

   // read data stands for one cycle after the strobe only
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= 32'h0;
      end else begin
         o_rdata <= 32'h0;
         if (i_read) begin
            case (i_addr)
               `SCF_REG_IRQ_STATUS: o_rdata[`SCF_IRQ_W-1:0] <= irq_status;
               `SCF_REG_IRQ_MASK: o_rdata[`SCF_IRQ_W-1:0] <= irq_mask;
               `SCF_REG_STATE: begin
                  o_rdata[`SCF_ST_PROG_BIT] <= program_suspended_flag;
                  o_rdata[`SCF_ST_ERASE_BIT] <= erase_suspended_flag;
                  o_rdata[`SCF_ST_PENDING_BIT] <= (state == st_pending);
                  o_rdata[`SCF_ST_WEL_BIT] <= write_enable_latch;
                  o_rdata[`SCF_ST_WIP_BIT] <= i_wip;
               end
               `SCF_REG_LAST_CMD: o_rdata[8:0] <= {last_accept, held_code};
               default: o_rdata <= 32'h0;
            endcase
         end
      end
   end
endmodule

// ==== scf_suspend_filter_props.sv ====
// checker for the suspend command filter, watching its ports only
// assumes scf_regs.svh and scf_pkg are compiled ahead of this file
`timescale 1ns/1ps
`include "scf_regs.svh"
module scf_suspend_filter_props (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // array engine side
   input wire logic i_wip,
   input wire scf_pkg::scf_op_t i_op_kind,
   input wire logic o_suspend_start,
   input wire logic o_resume_start,
   // decoded stream and flags
   input wire logic o_cmd_valid,
   input wire logic o_cmd_accept,
   input wire logic [7:0] o_cmd_code,
   input wire logic o_program_suspended,
   input wire logic o_erase_suspended,
   input wire logic o_write_enable_latch
);
   import scf_pkg::*;
   logic [11:0] lat_cnt;
   // -----------------------------------------------
   // helper logic
   // -----------------------------------------------
   // cycles since suspend; saturates so a stray flag rise trips the check
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lat_cnt <= 12'hfff;
      end else if (o_suspend_start) begin
         lat_cnt <= 12'h000;
      end else if (lat_cnt != 12'hfff) begin
         lat_cnt <= lat_cnt + 12'h001;
      end
   end
   // -----------------------------------------------
   // properties
   // -----------------------------------------------
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   a_accept_needs_valid: assert property (o_cmd_accept |-> o_cmd_valid)
      else $error("accept seen without a captured byte");
   a_flags_exclusive: assert property (!(o_program_suspended && o_erase_suspended))
      else $error("both suspended flags set");
   a_wel_cleared: assert property ($rose(o_program_suspended || o_erase_suspended)
      |-> !o_write_enable_latch) else $error("write enable latch kept on suspend");
   a_suspend_needs_busy: assert property (o_suspend_start
      |-> $past(i_wip) && ($past(i_op_kind) inside {op_program, op_erase}))
      else $error("suspend started without a program or erase running");
   a_suspend_code: assert property (o_suspend_start |-> o_cmd_code == 8'h75)
      else $error("suspend started by another code");
   a_prog_latency: assert property ($rose(o_program_suspended)
      |-> lat_cnt >= `SCF_PSL_CYC - 2 && lat_cnt <= `SCF_PSL_CYC + 2)
      else $error("program flag rose off the suspend latency");
   a_erase_latency: assert property ($rose(o_erase_suspended)
      |-> lat_cnt >= `SCF_ESL_CYC - 2 && lat_cnt <= `SCF_ESL_CYC + 2)
      else $error("erase flag rose off the suspend latency");
   a_resume_clears: assert property (o_resume_start
      |-> !o_program_suspended && !o_erase_suspended)
      else $error("flag still set at resume");
   a_resume_needs_idle: assert property (o_resume_start
      |-> $past(o_program_suspended || o_erase_suspended) && !$past(i_wip))
      else $error("resume acted while not suspended or busy");
endmodule

// ==== scf_host_model.sv ====
// host-side serial master: one instruction byte per chip-select frame
// assumes i_quad mirrors the device's quad command mode flag
`timescale 1ns/1ps
module scf_host_model (
   // mode
   input wire logic i_quad,
   // serial pins
   output logic o_sck,
   output logic o_cs_n,
   output logic [3:0] o_io
);
   // idle: clock stands low, chip select high
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_io = 4'h5;
   end
   // msb first; released lines are inverted so no stale bit looks valid
   task automatic send_frame(input logic [7:0] b);
      int i;
      logic q;
      q = i_quad;
      o_cs_n = 1'b0;
      #100;
      for (i = 0; i < (q ? 2 : 8); i++) begin
         o_io = q ? (i == 0 ? b[7:4] : b[3:0]) : {~o_io[3:1], b[7-i]};
         #100 o_sck = 1'b1;
         #100 o_sck = 1'b0;
      end
      #100 o_cs_n = 1'b1;
      o_io = ~o_io;
      #400;
   endtask
endmodule

// ==== test_scf_suspend_filter.sv ====
// self-checking bench for the suspend command filter
// assumes the host model and the checker are compiled ahead of this file
`timescale 1ns/1ps
`include "scf_regs.svh"
module test_scf_suspend_filter;
   import scf_pkg::*;
   logic i_clock = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_sck, i_cs_n, o_suspend_start, o_resume_start, o_cmd_valid;
   logic o_cmd_accept, o_program_suspended, o_erase_suspended, o_irq;
   logic o_write_enable_latch, o_quad_command_mode, seen_acc;
   logic [3:0] i_io;
   logic i_wip = 1'b0;
   scf_op_t i_op_kind = op_none;
   logic [7:0] o_cmd_code, seen_code;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic i_write = 1'b0;
   logic i_read = 1'b0;
   logic [31:0] o_rdata;
   int err_total = 0;
   int checks_done = 0;
   int seen_cnt = 0;
   // rows: {accepted in program suspend, in erase suspend, code}
   logic [9:0] rows [0:59] = '{10'h306, 10'h304, 10'h3c8, 10'h3c5,
      10'h3b7, 10'h3e9, 10'h338, 10'h3ff, 10'h303, 10'h313, 10'h30b,
      10'h30d, 10'h30c, 10'h33b, 10'h33c, 10'h36b, 10'h36c, 10'h3bb,
      10'h3bd, 10'h3bc, 10'h3eb, 10'h3ed, 10'h3ec, 10'h3ee, 10'h3e7,
      10'h377, 10'h3c0, 10'h390, 10'h392, 10'h394, 10'h39f, 10'h34b,
      10'h3ab, 10'h348, 10'h35a, 10'h32d, 10'h3a7, 10'h3e2, 10'h33d,
      10'h3aa, 10'h327, 10'h305, 10'h335, 10'h315, 10'h366, 10'h102,
      10'h112, 10'h132, 10'h134, 10'h220, 10'h221, 10'h252, 10'h25c,
      10'h2d8, 10'h2dc, 10'h075, 10'h060, 10'h0c7, 10'h001, 10'h0e3};
   // -----------------------------------------------
   // clock, design, partner
   // -----------------------------------------------
   always #12.5 i_clock = ~i_clock;
   scf_suspend_filter i_scf_suspend_filter (.i_clock, .i_reset_n, .i_sck,
      .i_cs_n, .i_io, .i_wip, .i_op_kind, .o_suspend_start, .o_resume_start,
      .o_cmd_valid, .o_cmd_accept, .o_cmd_code, .o_program_suspended,
      .o_erase_suspended, .o_write_enable_latch, .o_quad_command_mode,
      .i_addr, .i_wdata, .i_write, .i_read, .o_rdata, .o_irq);
   scf_host_model i_scf_host_model (.i_quad(o_quad_command_mode),
      .o_sck(i_sck), .o_cs_n(i_cs_n), .o_io(i_io));
   // capture each decoded byte; valid stands one cycle only
   always @(posedge i_clock) begin
      if (o_cmd_valid === 1'b1) begin
         seen_code <= o_cmd_code;
         seen_acc <= o_cmd_accept;
         seen_cnt <= seen_cnt + 1;
      end
   end
   // -----------------------------------------------
   // tasks
   // -----------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic bail();
      err_total++;
      tally_and_finish();
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("FAIL %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_write <= 1'b1;
      @(posedge i_clock);
      i_write <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_clock);
      i_addr <= a;
      i_read <= 1'b1;
      @(posedge i_clock);
      i_read <= 1'b0;
      #1 chk("rdata", exp, o_rdata);
   endtask
   task automatic send(input logic [7:0] code, input logic exp);
      int n0;
      int k;
      n0 = seen_cnt;
      // pins move off the sampling edge; return lands on a rising one
      @(negedge i_clock);
      i_scf_host_model.send_frame(code);
      @(posedge i_clock);
      k = 0;
      while (seen_cnt == n0 && k < 200) begin
         @(posedge i_clock);
         k++;
      end
      if (seen_cnt == n0) bail();
      chk("code", {24'h0, code}, {24'h0, seen_code});
      chk("accept", {31'h0, exp}, {31'h0, seen_acc});
   endtask
   // mode 0 run, 1 program suspended, 2 erase suspended
   task automatic run_table(input int mode);
      for (int i = 0; i < 60; i++) begin
         send(rows[i][7:0], mode == 0 ? rows[i][7:0] != 8'h75 :
            rows[i][10-mode]);
      end
   endtask
   task automatic suspend_resume(input logic prog);
      int k;
      send(8'h06, 1'b1);
      send(8'h75, 1'b1);
      i_wip <= 1'b0;
      send(8'h05, 1'b1);
      send(8'h66, 1'b1);
      send(8'h03, 1'b0);
      k = 0;
      // the host holds back until the latency has run out
      while ((prog ? o_program_suspended : o_erase_suspended) !== 1'b1
             && k < 1000) begin
         @(posedge i_clock);
         k++;
      end
      if (k >= 1000) bail();
      chk("wel", 32'h0, {31'h0, o_write_enable_latch});
      rd_chk(`SCF_REG_STATE, prog ? 32'h8000 : 32'h0400);
      run_table(prog ? 1 : 2);
      chk("flags", {30'h0, prog, ~prog},
         {30'h0, o_program_suspended, o_erase_suspended});
      i_wip <= 1'b1;
      send(8'h7a, 1'b0);
      i_wip <= 1'b0;
      send(8'h7a, 1'b1);
      chk("flags", 32'h0,
         {30'h0, o_program_suspended, o_erase_suspended});
      rd_chk(`SCF_REG_IRQ_STATUS, 32'h7);
      wr(`SCF_REG_IRQ_STATUS, 32'h7);
      i_wip <= 1'b1;
   endtask
   // -----------------------------------------------
   // main sequence
   // -----------------------------------------------
   initial begin
      repeat (20) @(posedge i_clock);
      chk("outputs", 32'h0, {o_rdata[25:0], o_cmd_valid, o_suspend_start,
         o_program_suspended, o_erase_suspended, o_irq, o_resume_start});
      i_reset_n <= 1'b1;
      repeat (4) @(posedge i_clock);
      rd_chk(`SCF_REG_IRQ_STATUS, 32'h0);
      rd_chk(`SCF_REG_IRQ_MASK, 32'h0);
      rd_chk(`SCF_REG_STATE, 32'h0);
      rd_chk(8'h10, 32'h0);
      wr(`SCF_REG_IRQ_MASK, 32'h3);
      send(8'h7a, 1'b0);
      repeat (3) @(posedge i_clock);
      chk("irq", 32'h0, {31'h0, o_irq});
      rd_chk(`SCF_REG_IRQ_STATUS, 32'h4);
      wr(`SCF_REG_IRQ_MASK, 32'h7);
      repeat (3) @(posedge i_clock);
      chk("irq", 32'h1, {31'h0, o_irq});
      wr(`SCF_REG_IRQ_STATUS, 32'h4);
      repeat (3) @(posedge i_clock);
      chk("irq", 32'h0, {31'h0, o_irq});
      run_table(0);
      i_wip <= 1'b1;
      i_op_kind <= op_program;
      suspend_resume(1'b1);
      i_op_kind <= op_erase;
      suspend_resume(1'b0);
      i_op_kind <= op_status;
      send(8'h75, 1'b0);
      // software reset while a suspend is still pending returns to run
      i_op_kind <= op_program;
      send(8'h75, 1'b1);
      send(8'h66, 1'b1);
      send(8'h99, 1'b1);
      rd_chk(`SCF_REG_STATE, 32'h1);
      rd_chk(`SCF_REG_LAST_CMD, 32'h199);
      send(8'h38, 1'b1);
      chk("quad", 32'h1, {31'h0, o_quad_command_mode});
      tally_and_finish();
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge i_clock);
      bail();
   end
endmodule
bind scf_suspend_filter scf_suspend_filter_props i_props (.i_clock,
   .i_reset_n, .i_wip, .i_op_kind, .o_suspend_start, .o_resume_start,
   .o_cmd_valid, .o_cmd_accept, .o_cmd_code, .o_program_suspended,
   .o_erase_suspended, .o_write_enable_latch);
